// file: rtl/bsc_pkg.sv
/*
  Constants for the boundary scan chain: chain length, cell positions,
  instruction codes and test access port controller states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package bsc_pkg;

  // ----------------------------------------------------------------
  // Chain geometry
  // ----------------------------------------------------------------
  localparam int          CHAIN_LEN     = 256;
  localparam int          IR_LEN        = 8;
  // Cell index is scan position minus one; index 0 sits next to TDI.
  localparam int          POS_GPIO3     = 0;
  localparam int          POS_GPIO2     = 255;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  INSN_EXTEST   = 8'h00;
  localparam logic [7:0]  INSN_SAMPLE   = 8'h01;
  localparam logic [7:0]  INSN_RESET    = 8'hFF;
  localparam logic [7:0]  IR_CAPTURE    = 8'h01;

  // ----------------------------------------------------------------
  // Test access port controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SH_DR   = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PA_DR   = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UPD_DR  = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'hA,
    TAP_SH_IR   = 4'hB,
    TAP_EX1_IR  = 4'hC,
    TAP_PA_IR   = 4'hD,
    TAP_EX2_IR  = 4'hE,
    TAP_UPD_IR  = 4'hF
  } bsc_tap_e;

endpackage : bsc_pkg

`default_nettype wire

// file: rtl/bsc_boundary_scan_chain.sv
/*
  Boundary scan chain with its test access port controller, instruction
  register and bypass bit. The chain and controller run on the test clock.
  Assumes the device pin levels arrive on the system clock and that the
  update latches are consumed by system clock logic; both cross properly.
*/
`timescale 1ns/10ps
`default_nettype none

module bsc_boundary_scan_chain
  import bsc_pkg::*;
#(
  parameter int CHAIN_W = CHAIN_LEN
)(
  // System clock domain
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Test port pins, on the test clock
  input  wire logic               tck,
  input  wire logic               trstN,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdoEn,
  // Device pin levels, index = scan position minus one
  input  wire logic [CHAIN_W-1:0] pinIn,
  // Update latch values and test override, on the system clock
  output logic      [CHAIN_W-1:0] pinOut,
  output logic                    extestEn
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bsc_tap_e           tapQ,      tapD;
  logic [IR_LEN-1:0]  irShQ,     irShD;
  logic [IR_LEN-1:0]  irQ,       irD;
  logic [CHAIN_W-1:0] bsrQ,      bsrD;
  logic [CHAIN_W-1:0] updQ,      updD;
  logic               bypQ,      bypD;
  logic               tdoQ,      tdoD;
  logic               tdoEnQ,    tdoEnD;
  logic [CHAIN_W-1:0] pinMetaQ;
  logic [CHAIN_W-1:0] pinSyncQ;
  logic [CHAIN_W-1:0] outMetaQ;
  logic [CHAIN_W-1:0] outSyncQ;
  logic               extMetaQ;
  logic               extSyncQ;
  logic               extTckQ,   extTckD;
  logic               bsrSel;
  logic               capDr;
  logic               shDr;
  logic               updDr;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------

  // Standard sixteen-state walk; five clocks of TMS high reach reset.
  always_comb
  begin
    case (tapQ)
      TAP_RESET:  tapD = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tapD = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tapD = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tapD = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tapD = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tapD = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tapD = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tapD = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tapD = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tapD = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tapD = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tapD = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tapD = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tapD = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tapD = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tapD = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tapD = TAP_RESET;
    endcase
  end

  // Decoded data register phases, gated by the selected instruction.
  assign bsrSel = (irQ == INSN_EXTEST) || (irQ == INSN_SAMPLE);
  assign capDr  = (tapQ == TAP_CAP_DR) && bsrSel;
  assign shDr   = (tapQ == TAP_SH_DR) && bsrSel;
  assign updDr  = (tapQ == TAP_UPD_DR) && bsrSel;

  // Test override is decoded and registered on the test clock first.
  // The crossing then sees a single flop, never a glitching comparator.
  assign extTckD = (irD == INSN_EXTEST);

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------

  // Enters at the top and moves down, so the first bit lands in bit 0.
  always_comb
  begin
    irShD = irShQ;
    irD   = irQ;
    case (tapQ)
      TAP_RESET:  irD   = INSN_RESET;
      TAP_CAP_IR: irShD = IR_CAPTURE;
      TAP_SH_IR:  irShD = {tdi, irShQ[IR_LEN-1:1]};
      TAP_UPD_IR: irD   = irShQ;
      default:    irD   = irQ;
    endcase
  end

  // ----------------------------------------------------------------
  // Boundary cells
  // ----------------------------------------------------------------

  // Each cell captures its pin, or takes its lower neighbour on a shift.
  // Cell 0 is fed from TDI, so position 1 owns general-purpose I/O bit 3.
  genvar gi;
  generate
    for (gi = 0; gi < CHAIN_W; gi++)
    begin : g_cell
      if (gi == 0)
      begin : g_first
        assign bsrD[gi] = capDr ? pinSyncQ[gi] :
                          shDr  ? tdi          :
                                  bsrQ[gi];
      end
      else
      begin : g_rest
        assign bsrD[gi] = capDr ? pinSyncQ[gi] :
                          shDr  ? bsrQ[gi-1]   :
                                  bsrQ[gi];
      end
      // Latches move only in update so pins do not ripple during a shift.
      assign updD[gi] = updDr ? bsrQ[gi] : updQ[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bypass bit and TDO
  // ----------------------------------------------------------------

  // The last cell, position 256, is what the tester sees first.
  always_comb
  begin
    bypD   = (tapQ == TAP_SH_DR) ? tdi : 1'b0;
    tdoD   = 1'b0;
    tdoEnD = 1'b0;
    if (tapQ == TAP_SH_IR)
    begin
      tdoD   = irShQ[0];
      tdoEnD = 1'b1;
    end
    else if (tapQ == TAP_SH_DR)
    begin
      tdoD   = bsrSel ? bsrQ[CHAIN_W-1] : bypQ;
      tdoEnD = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Test clock registers
  // ----------------------------------------------------------------

  // TRST low resets the port; the chain is untouched by system reset.
  always_ff @(posedge tck)
  begin
    if (!trstN)
    begin
      tapQ   <= TAP_RESET;
      irShQ  <= INSN_RESET;
      irQ    <= INSN_RESET;
      bsrQ   <= '0;
      updQ   <= '0;
      bypQ   <= 1'b0;
      tdoQ   <= 1'b0;
      tdoEnQ <= 1'b0;
      extTckQ <= 1'b0;
    end
    else
    begin
      tapQ   <= tapD;
      irShQ  <= irShD;
      irQ    <= irD;
      bsrQ   <= bsrD;
      updQ   <= updD;
      bypQ   <= bypD;
      tdoQ   <= tdoD;
      tdoEnQ <= tdoEnD;
      extTckQ <= extTckD;
    end
  end

  // Pin levels cross into the test clock; each pin is its own level.
  always_ff @(posedge tck)
  begin
    pinMetaQ <= pinIn;
    pinSyncQ <= pinMetaQ;
  end

  assign tdo   = tdoQ;
  assign tdoEn = tdoEnQ;

  // ----------------------------------------------------------------
  // Crossing back to the system clock
  // ----------------------------------------------------------------

  // Latch values change only in update, so per-bit level sync is enough;
  // a bit may land one system clock before its neighbour.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      outMetaQ <= '0;
      outSyncQ <= '0;
      extMetaQ <= 1'b0;
      extSyncQ <= 1'b0;
    end
    else
    begin
      outMetaQ <= updQ;
      outSyncQ <= outMetaQ;
      extMetaQ <= extTckQ;
      extSyncQ <= extMetaQ;
    end
  end

  assign pinOut   = outSyncQ;
  assign extestEn = extSyncQ;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  AST_TDI_INTO_LSB: assert property (
    @(posedge tck) disable iff (!trstN)
    shDr |=> bsrQ[0] == $past(tdi))
  else $error("TDI bit not loaded into first cell");

  AST_CHAIN_MOVES: assert property (
    @(posedge tck) disable iff (!trstN)
    shDr |=> bsrQ[CHAIN_W-1:1] == $past(bsrQ[CHAIN_W-2:0]))
  else $error("Chain did not move by one cell");

  AST_TDO_FROM_MSB: assert property (
    @(posedge tck) disable iff (!trstN)
    shDr |=> tdoQ == $past(bsrQ[CHAIN_W-1]) && tdoEnQ)
  else $error("TDO is not the last cell");

  AST_GPIO2_OUT_FIRST: assert property (
    @(posedge tck) disable iff (!trstN)
    capDr ##1 shDr |=> tdoQ == $past(pinSyncQ[POS_GPIO2], 2))
  else $error("Position 256 is not shifted out first");

  AST_IR_LSB_FIRST: assert property (
    @(posedge tck) disable iff (!trstN)
    (tapQ == TAP_SH_IR) [*8] |=> irShQ[0] == $past(tdi, 8))
  else $error("Instruction not shifted least significant bit first");

  AST_SELECT_CODES: assert property (
    @(posedge tck) disable iff (!trstN)
    (tapQ == TAP_SH_DR && (irQ == INSN_EXTEST || irQ == INSN_SAMPLE))
    |=> bsrQ[0] == $past(tdi) && tdoQ == $past(bsrQ[CHAIN_W-1]))
  else $error("Boundary register not selected for its codes");

  AST_BYPASS_HOLDS: assert property (
    @(posedge tck) disable iff (!trstN)
    (tapQ == TAP_SH_DR && irQ != INSN_EXTEST && irQ != INSN_SAMPLE)
    |=> $stable(bsrQ) && tdoQ == $past(bypQ))
  else $error("Boundary register moved under another code");

  AST_TDO_IDLE: assert property (
    @(posedge tck) disable iff (!trstN)
    (tapQ != TAP_SH_DR && tapQ != TAP_SH_IR) |=> !tdoEnQ && !tdoQ)
  else $error("TDO driven outside a shift state");

  AST_RESET_CODE: assert property (
    @(posedge tck) disable iff (!trstN)
    (tapQ == TAP_RESET) |=> irQ == INSN_RESET)
  else $error("Reset state did not restore the idle code");

  AST_CAPTURE_PINS: assert property (
    @(posedge tck) disable iff (!trstN)
    capDr |=> bsrQ == $past(pinSyncQ))
  else $error("Pin levels not captured");

  AST_UPDATE_ONLY: assert property (
    @(posedge tck) disable iff (!trstN)
    !updDr |=> $stable(updQ))
  else $error("Latches changed outside update");

  AST_EXTEST_OUT: assert property (
    @(posedge clk_sys) disable iff (rst)
    extTckQ [*3] |=> extSyncQ)
  else $error("Test override did not reach the system clock");

  AST_EXTEST_OFF: assert property (
    @(posedge clk_sys) disable iff (rst)
    !extTckQ [*3] |=> !extSyncQ)
  else $error("Test override stayed on after the code changed");

endmodule : bsc_boundary_scan_chain

`default_nettype wire

// file: verif/bsc_tester.sv
/*
  Tester model: drives the test port pins and walks the port controller.
  Assumes the block samples tms and tdi on the rising test clock and
  registers tdo on that same edge.
*/
`timescale 1ns/10ps
`default_nettype none

module bsc_tester
  import bsc_pkg::*;
(
  // Test port pins
  output logic      tck,
  output logic      trstN,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoEn
);
  // The test clock stands still low between frames.
  initial
  begin
    tck = 1'b0;
    trstN = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 48 ns test clock cycle; tdo is read just after the rising edge.
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #24 tck = 1'b1;
    #1 o = tdo;
    #23 tck = 1'b0;
  endtask : step

  // Hold test reset over two edges, then settle in run-idle.
  task automatic hold_reset();
    logic o;
    trstN = 1'b0;
    step(1'b1, 1'b0, o);
    step(1'b1, 1'b0, o);
    trstN = 1'b1;
    step(1'b0, 1'b0, o);
  endtask : hold_reset

  // Five high mode-select edges reach the reset state without test reset.
  task automatic tms_reset();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : tms_reset

  // Instruction goes in least significant bit first; capture comes back.
  task automatic load_ir(input logic [7:0] code, output logic [7:0] capt);
    logic o;
    step(1'b1, 1'b0, o);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < IR_LEN; i++)
    begin
      step(i == IR_LEN - 1, code[i], o);
      capt[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : load_ir

  // Full data scan; bit i of each vector is scan position i+1.
  task automatic scan_dr(input logic [255:0] vin, output logic [255:0] vout,
                         output logic en);
    logic o;
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < CHAIN_LEN; i++)
    begin
      step(i == CHAIN_LEN - 1, vin[255-i], o);
      vout[255-i] = o;
      if (i == 128)
        en = tdoEn;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : scan_dr
endmodule : bsc_tester

`default_nettype wire

// file: verif/boundary_scan_chain_tb.sv
/*
  Self-checking bench for the boundary scan chain.
  Assumes the tester model drives the test port and that update latches
  reach pinOut within four system clocks.
*/
`timescale 1ns/10ps
`default_nettype none

module boundary_scan_chain_tb;
  import bsc_pkg::*;

  logic                 clkSys;
  logic                 rst;
  logic                 tck;
  logic                 trstN;
  logic                 tms;
  logic                 tdi;
  logic                 tdo;
  logic                 tdoEn;
  logic                 extestEn;
  logic [CHAIN_LEN-1:0] pinIn;
  logic [CHAIN_LEN-1:0] pinOut;
  logic [CHAIN_LEN-1:0] got;
  logic [CHAIN_LEN-1:0] patA;
  logic [CHAIN_LEN-1:0] patB;
  logic [7:0]           capt;
  logic                 en;
  int                   failCount;
  int                   totalChecks;

  bsc_boundary_scan_chain #(.CHAIN_W(CHAIN_LEN)) DUT (
    .clk_sys(clkSys), .rst(rst), .tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn), .pinOut(pinOut), .extestEn(extestEn));

  bsc_tester tester (
    .tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));

  // 250 MHz system clock.
  initial
  begin
    clkSys = 1'b0;
    forever #2 clkSys = ~clkSys;
  end

  task automatic check(input logic [CHAIN_LEN-1:0] seen, input logic [CHAIN_LEN-1:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic sys_wait(input int n);
    repeat (n) @(negedge clkSys);
  endtask : sys_wait

  task automatic giveVerdict();
    $display("Checks %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : giveVerdict

  // Capture, scan out and preload through the sampling instruction.
  task automatic test_sample();
    pinIn = patA;
    tester.load_ir(INSN_SAMPLE, capt);
    check(capt, IR_CAPTURE);
    sys_wait(4);
    check(extestEn, 1'b0);
    tester.scan_dr(patB, got, en);
    check(got, patA);
    check({got[POS_GPIO2], got[POS_GPIO3]}, {patA[255], patA[0]});
    check(en, 1'b1);
    check(tdoEn, 1'b0);
    sys_wait(4);
    check(pinOut, patB);
  endtask : test_sample

  // Test mode rises on the boundary instruction; system reset spares the chain.
  task automatic test_extest();
    tester.load_ir(INSN_EXTEST, capt);
    sys_wait(4);
    check(extestEn, 1'b1);
    rst = 1'b1;
    sys_wait(2);
    check(extestEn, 1'b0);
    check(pinOut, '0);
    rst = 1'b0;
    sys_wait(4);
    check(extestEn, 1'b1);
    check(pinOut, patB);
  endtask : test_extest

  // Other codes leave a one-bit path and never touch the latches.
  task automatic test_bypass();
    tester.load_ir(8'h10, capt);
    sys_wait(4);
    check(extestEn, 1'b0);
    tester.scan_dr(patA, got, en);
    check(got[254:0], patA[255:1]);
    sys_wait(4);
    check(pinOut, patB);
  endtask : test_bypass

  // Mode-select reset returns to the idle code but keeps the latches.
  task automatic test_tms_reset();
    tester.load_ir(INSN_EXTEST, capt);
    tester.tms_reset();
    sys_wait(4);
    check(extestEn, 1'b0);
    check(pinOut, patB);
  endtask : test_tms_reset

  // Main sequence; inputs change at the falling system clock edge.
  initial
  begin
    failCount = 0;
    totalChecks = 0;
    rst = 1'b1;
    pinIn = '0;
    patA = {32'h8123_4567, {6{32'h0F1E_2D3C}}, 32'h5A69_7885};
    patB = ~patA;
    sys_wait(4);
    rst = 1'b0;
    tester.hold_reset();
    test_sample();
    test_extest();
    test_bypass();
    test_tms_reset();
    giveVerdict();
  end

  // A hang is cut short well after a normal run would end.
  initial
  begin
    #200000;
    failCount++;
    giveVerdict();
  end
endmodule : boundary_scan_chain_tb

`default_nettype wire
